//--- rtl/fault_resp_pkg.sv
// Command codes, field layout, reset values and timing for the fault response block
package fault_resp_pkg;
    localparam logic [7:0] CMD_UT_WARN = 8'h52;
    localparam logic [7:0] CMD_UT_ACT = 8'h54;
    localparam logic [7:0] CMD_OV_FAULT = 8'h55;
    localparam logic [7:0] CMD_OV_ACT = 8'h56;
    localparam logic [7:0] CMD_OV_WARN = 8'h57;
    localparam int ACT_MODE_HI = 7;
    localparam int ACT_MODE_LO = 6;
    localparam int ACT_CNT_HI = 5;
    localparam int ACT_CNT_LO = 3;
    localparam int ACT_TIME_HI = 2;
    localparam int ACT_TIME_LO = 0;
    localparam logic [1:0] MODE_RETRY = 2'h2;
    localparam logic [1:0] MODE_RESUME = 2'h3;
    localparam logic [2:0] CNT_NONE = 3'h0;
    localparam logic [2:0] CNT_FOREVER = 3'h7;
    localparam logic [15:0] RST_OV_FAULT = 16'hffff;
    localparam logic [15:0] RST_OV_WARN = 16'hffff;
    localparam logic [15:0] RST_UT_WARN = 16'h0000;
    localparam logic [7:0] RST_ACT = 8'h80;
    localparam int RETRY_STEP_MS = 35;
    localparam int CLK_HZ = 250_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int MS_CNT_W = 9;
    localparam int TRY_W = 3;
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_WAIT = 4'h2,
        ST_HOLD = 4'h4,
        ST_LATCH = 4'h8
    } chan_state_t;
endpackage : fault_resp_pkg

//--- rtl/fault_chan.sv
// Per-fault shutdown, retry and resume sequencer
`timescale 1ns/100ps
module fault_chan (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ms_tick,
    input wire logic fault,
    input wire logic resume_ok,
    input wire logic run_cmd,
    input wire logic clear,
    input wire logic [7:0] action,
    output logic off_next
);
    typedef struct packed {
        fault_resp_pkg::chan_state_t st;
        logic [fault_resp_pkg::MS_CNT_W-1:0] ms;
        logic [fault_resp_pkg::TRY_W-1:0] tries;
    } chan_q_t;

    chan_q_t q;
    chan_q_t d;
    logic [1:0] mode;
    logic [2:0] cnt;
    logic [2:0] tim;
    logic [fault_resp_pkg::MS_CNT_W-1:0] limit;

    assign mode = action[fault_resp_pkg::ACT_MODE_HI:fault_resp_pkg::ACT_MODE_LO];
    assign cnt = action[fault_resp_pkg::ACT_CNT_HI:fault_resp_pkg::ACT_CNT_LO];
    assign tim = action[fault_resp_pkg::ACT_TIME_HI:fault_resp_pkg::ACT_TIME_LO];
    // One extra tick, as the first tick may close only part of a ms
    assign limit = fault_resp_pkg::MS_CNT_W'((int'(tim) + 1)
        * fault_resp_pkg::RETRY_STEP_MS);

    always_comb
    begin
        d = q;
        case (q.st)
            fault_resp_pkg::ST_RUN:
            begin
                if (fault && mode == fault_resp_pkg::MODE_RESUME)
                begin
                    d.st = fault_resp_pkg::ST_HOLD;
                end
                else if (fault && mode == fault_resp_pkg::MODE_RETRY)
                begin
                    d.ms = '0;
                    if (cnt == fault_resp_pkg::CNT_FOREVER || q.tries < cnt)
                        d.st = fault_resp_pkg::ST_WAIT;
                    else
                        d.st = fault_resp_pkg::ST_LATCH;
                end
            end
            fault_resp_pkg::ST_WAIT:
            begin
                if (!run_cmd)
                    d.st = fault_resp_pkg::ST_RUN;
                else if (ms_tick && q.ms == limit)
                begin
                    d.st = fault_resp_pkg::ST_RUN;
                    if (cnt != fault_resp_pkg::CNT_FOREVER)
                        d.tries = q.tries + 1'b1;
                end
                else if (ms_tick)
                    d.ms = q.ms + 1'b1;
            end
            fault_resp_pkg::ST_HOLD:
            begin
                if (resume_ok && !fault)
                    d.st = fault_resp_pkg::ST_RUN;
            end
            fault_resp_pkg::ST_LATCH:
            begin
                if (clear && !fault)
                    d.st = fault_resp_pkg::ST_RUN;
            end
            default:
                d.st = fault_resp_pkg::ST_RUN;
        endcase
        if (clear || !run_cmd)
            d.tries = '0;
        off_next = d.st != fault_resp_pkg::ST_RUN;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            q <= '{st: fault_resp_pkg::ST_RUN, ms: '0, tries: '0};
        else
            q <= d;
    end

    AST_RETRY_SHUTDOWN: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == fault_resp_pkg::ST_RUN && fault && mode == fault_resp_pkg::MODE_RETRY
        |=> q.st inside {fault_resp_pkg::ST_WAIT, fault_resp_pkg::ST_LATCH})
        else $error("retry fault did not shut down");
    AST_RESUME_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
        (q.st == fault_resp_pkg::ST_RUN && fault && mode == fault_resp_pkg::MODE_RESUME)
        || (q.st == fault_resp_pkg::ST_HOLD && !(resume_ok && !fault))
        |=> q.st == fault_resp_pkg::ST_HOLD)
        else $error("resume fault left hold early");
    AST_NO_RETRY: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == fault_resp_pkg::ST_RUN && fault && mode == fault_resp_pkg::MODE_RETRY
        && cnt == fault_resp_pkg::CNT_NONE |=> q.st == fault_resp_pkg::ST_LATCH)
        else $error("zero retry count still retried");
    AST_CONT_RETRY: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == fault_resp_pkg::ST_RUN && fault && mode == fault_resp_pkg::MODE_RETRY
        && cnt == fault_resp_pkg::CNT_FOREVER |=> q.st == fault_resp_pkg::ST_WAIT)
        else $error("continuous retry latched off");
    AST_EXACT_TRIES: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == fault_resp_pkg::ST_RUN && fault && mode == fault_resp_pkg::MODE_RETRY
        && cnt != fault_resp_pkg::CNT_FOREVER && q.tries >= cnt
        |=> q.st == fault_resp_pkg::ST_LATCH)
        else $error("retry count exceeded");
    AST_RETRY_TIME: assert property (@(posedge ref_clk) disable iff (!rstn)
        q.st == fault_resp_pkg::ST_WAIT && run_cmd && ms_tick && q.ms != limit
        |=> q.st == fault_resp_pkg::ST_WAIT && q.ms == $past(q.ms) + 1'b1)
        else $error("retry wait ended early");
    COV_RETRY_RESTART: cover property (@(posedge ref_clk) disable iff (!rstn)
        q.st == fault_resp_pkg::ST_WAIT ##1 q.st == fault_resp_pkg::ST_RUN);
endmodule : fault_chan

//--- rtl/input_fault_response_ctrl.sv
// Input over-voltage and under-temperature fault response controller
`timescale 1ns/100ps
module input_fault_response_ctrl #(
    parameter int MS_CYCLES = fault_resp_pkg::MS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_word,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid,
    output logic rsp_err,
    output logic [15:0] rsp_rdata,
    input wire logic [15:0] vin_meas,
    input wire logic [15:0] temp_meas,
    input wire logic ov_fault_det,
    input wire logic ut_fault_det,
    input wire logic fault_clear,
    input wire logic output_cmd_on,
    output logic output_en,
    output logic alert_line_n,
    output logic ov_fault_flag,
    output logic ut_fault_flag
);
    localparam int DIV_W = $clog2(MS_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

    typedef struct packed {
        logic [15:0] ov_thr;
        logic [15:0] ov_warn;
        logic [15:0] ut_warn;
        logic [7:0] ov_act;
        logic [7:0] ut_act;
        logic [DIV_W-1:0] div;
        logic tick;
        logic rsp_valid;
        logic rsp_err;
        logic [15:0] rdata;
        logic out_en;
        logic alert_n;
        logic ov_flag;
        logic ut_flag;
    } top_q_t;

    top_q_t q;
    top_q_t d;
    logic hit;
    logic word_cmd;
    logic ok;
    logic [15:0] rd;
    logic ov_resume;
    logic ut_resume;
    logic ov_off;
    logic ut_off;

    assign ov_resume = vin_meas < q.ov_warn;
    assign ut_resume = temp_meas > q.ut_warn;

    fault_chan u_ov_chan (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ms_tick(q.tick),
        .fault(ov_fault_det),
        .resume_ok(ov_resume),
        .run_cmd(output_cmd_on),
        .clear(fault_clear),
        .action(q.ov_act),
        .off_next(ov_off)
    );

    fault_chan u_ut_chan (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ms_tick(q.tick),
        .fault(ut_fault_det),
        .resume_ok(ut_resume),
        .run_cmd(output_cmd_on),
        .clear(fault_clear),
        .action(q.ut_act),
        .off_next(ut_off)
    );

    always_comb
    begin
        d = q;
        hit = 1'b1;
        word_cmd = 1'b1;
        rd = '0;
        // Millisecond enable for the retry timers
        if (q.div == DIV_LAST)
        begin
            d.div = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.div = q.div + 1'b1;
            d.tick = 1'b0;
        end
        case (cmd_code)
            fault_resp_pkg::CMD_OV_FAULT: rd = q.ov_thr;
            fault_resp_pkg::CMD_OV_WARN: rd = q.ov_warn;
            fault_resp_pkg::CMD_UT_WARN: rd = q.ut_warn;
            fault_resp_pkg::CMD_OV_ACT:
            begin
                word_cmd = 1'b0;
                rd = {8'h00, q.ov_act};
            end
            fault_resp_pkg::CMD_UT_ACT:
            begin
                word_cmd = 1'b0;
                rd = {8'h00, q.ut_act};
            end
            default: hit = 1'b0;
        endcase
        // Wrong transfer size is refused like an unknown code
        ok = hit && (word_cmd == cmd_word);
        d.rsp_valid = cmd_valid;
        d.rsp_err = cmd_valid && !ok;
        d.rdata = (cmd_valid && ok && !cmd_write) ? rd : '0;
        if (cmd_valid && ok && cmd_write)
        begin
            case (cmd_code)
                fault_resp_pkg::CMD_OV_FAULT: d.ov_thr = cmd_wdata;
                fault_resp_pkg::CMD_OV_WARN: d.ov_warn = cmd_wdata;
                fault_resp_pkg::CMD_UT_WARN: d.ut_warn = cmd_wdata;
                fault_resp_pkg::CMD_OV_ACT: d.ov_act = cmd_wdata[7:0];
                fault_resp_pkg::CMD_UT_ACT: d.ut_act = cmd_wdata[7:0];
                default: d.ov_thr = q.ov_thr;
            endcase
        end
        // Sticky flags, a fault in the clear cycle wins
        d.ov_flag = ov_fault_det || (q.ov_flag && !fault_clear);
        d.ut_flag = ut_fault_det || (q.ut_flag && !fault_clear);
        d.alert_n = !(d.ov_flag || d.ut_flag);
        d.out_en = output_cmd_on && !ov_off && !ut_off;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            q <= '{ov_thr: fault_resp_pkg::RST_OV_FAULT, ov_warn: fault_resp_pkg::RST_OV_WARN,
                   ut_warn: fault_resp_pkg::RST_UT_WARN, ov_act: fault_resp_pkg::RST_ACT,
                   ut_act: fault_resp_pkg::RST_ACT, div: '0, tick: 1'b0, rsp_valid: 1'b0,
                   rsp_err: 1'b0, rdata: '0, out_en: 1'b0, alert_n: 1'b1,
                   ov_flag: 1'b0, ut_flag: 1'b0};
        end
        else
            q <= d;
    end

    assign rsp_valid = q.rsp_valid;
    assign rsp_err = q.rsp_err;
    assign rsp_rdata = q.rdata;
    assign output_en = q.out_en;
    assign alert_line_n = q.alert_n;
    assign ov_fault_flag = q.ov_flag;
    assign ut_fault_flag = q.ut_flag;

    AST_ALERT_ON_FAULT: assert property (@(posedge ref_clk) disable iff (!rstn)
        ov_fault_det || ut_fault_det
        |=> !alert_line_n && (ov_fault_flag || !$past(ov_fault_det))
            && (ut_fault_flag || !$past(ut_fault_det)))
        else $error("fault did not pull alert low");
    AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!rstn)
        ov_fault_flag && !fault_clear |=> ov_fault_flag && !alert_line_n)
        else $error("fault flag dropped without clear");
    // Output on means both channels run, so a disabling fault turns it off
    AST_OV_OFF_AT_ONCE: assert property (@(posedge ref_clk) disable iff (!rstn)
        output_en && ov_fault_det && q.ov_act[fault_resp_pkg::ACT_MODE_HI] |=> !output_en)
        else $error("output stayed on after fault");
    AST_UT_OFF_AT_ONCE: assert property (@(posedge ref_clk) disable iff (!rstn)
        output_en && ut_fault_det && q.ut_act[fault_resp_pkg::ACT_MODE_HI] |=> !output_en)
        else $error("output stayed on after fault");
    AST_WORD_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
        cmd_valid && cmd_write && cmd_word && cmd_code == fault_resp_pkg::CMD_OV_FAULT
        |=> rsp_valid && !rsp_err && q.ov_thr == $past(cmd_wdata))
        else $error("threshold word write lost");
    AST_BYTE_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
        cmd_valid && cmd_word && cmd_code == fault_resp_pkg::CMD_OV_ACT
        |=> rsp_valid && rsp_err && q.ov_act == $past(q.ov_act))
        else $error("word access to action byte accepted");
    // Command port answers
    AST_ANSWER_NEXT: assert property (@(posedge ref_clk) disable iff (!rstn)
        cmd_valid |=> rsp_valid)
        else $error("command got no answer");
    AST_WORD_REFUSED: assert property (@(posedge ref_clk) disable iff (!rstn)
        cmd_valid && !cmd_word && cmd_code == fault_resp_pkg::CMD_OV_FAULT
        |=> rsp_err && rsp_rdata == 16'h0000 && q.ov_thr == $past(q.ov_thr))
        else $error("byte access to threshold accepted");
    AST_BYTE_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
        cmd_valid && !cmd_write && !cmd_word && cmd_code == fault_resp_pkg::CMD_OV_ACT
        |=> rsp_valid && !rsp_err && rsp_rdata == {8'h00, $past(q.ov_act)})
        else $error("action byte read wrong");
    AST_UT_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!rstn)
        ut_fault_flag && !fault_clear |=> ut_fault_flag && !alert_line_n)
        else $error("fault flag dropped without clear");
    COV_ALERT: cover property (@(posedge ref_clk) disable iff (!rstn)
        alert_line_n ##1 !alert_line_n);
    COV_OV_RESUME: cover property (@(posedge ref_clk) disable iff (!rstn)
        !output_en && output_cmd_on && ov_resume ##1 output_en);
    COV_UT_RESUME: cover property (@(posedge ref_clk) disable iff (!rstn)
        !output_en && output_cmd_on && ut_resume ##1 output_en);
    COV_REFUSED: cover property (@(posedge ref_clk) disable iff (!rstn)
        rsp_valid && rsp_err);
endmodule : input_fault_response_ctrl

//--- tb/pmbus_host_model.sv
// Host model issuing one command-port transfer at a time
`timescale 1ns/100ps
module pmbus_host_model (
    input wire logic ref_clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic cmd_word,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [15:0] rsp_rdata
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_word = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task xfer(input logic wr, input logic wd, input logic [7:0] code, input logic [15:0] wdata,
              output logic [15:0] rd, output logic err, output logic seen);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_word = wd;
        cmd_code = code;
        cmd_wdata = wdata;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        // Idle code and data lines show inverted values
        cmd_code = ~code;
        cmd_wdata = ~wdata;
        seen = rsp_valid;
        err = rsp_err;
        rd = rsp_rdata;
    endtask : xfer
endmodule : pmbus_host_model

//--- tb/input_fault_response_ctrl_test.sv
// Self-checking bench for the input fault response controller
`timescale 1ns/100ps
module input_fault_response_ctrl_test;
    localparam int MSC = 4;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid, cmd_write, cmd_word, rsp_valid, rsp_err, err, seen;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata, rd;
    logic [15:0] vin_meas = 16'h0000;
    logic [15:0] temp_meas = 16'h0100;
    logic ov_fault_det = 1'b0, ut_fault_det = 1'b0, fault_clear = 1'b0, output_cmd_on = 1'b1;
    logic output_en, alert_line_n, ov_fault_flag, ut_fault_flag;
    logic [7:0] codes [5] = '{8'h52, 8'h54, 8'h55, 8'h56, 8'h57};
    logic [5:0] rcase [5] = '{6'h00, 6'h08, 6'h30, 6'h38, 6'h17};
    int mismatches = 0;
    int n_tests = 0;
    int seed = 29;
    int reg_m [int];
    always #2 ref_clk = ~ref_clk;
    pmbus_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata));
    input_fault_response_ctrl #(.MS_CYCLES(MSC)) dut (.ref_clk(ref_clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .vin_meas(vin_meas), .temp_meas(temp_meas),
        .ov_fault_det(ov_fault_det), .ut_fault_det(ut_fault_det), .fault_clear(fault_clear),
        .output_cmd_on(output_cmd_on), .output_en(output_en), .alert_line_n(alert_line_n),
        .ov_fault_flag(ov_fault_flag), .ut_fault_flag(ut_fault_flag));
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    function automatic logic is_word(input logic [7:0] c);
        return c != 8'h54 && c != 8'h56;
    endfunction : is_word
    task access(input logic wr, input logic wd, input logic [7:0] code, input logic [15:0] d);
        logic bad;
        bad = !reg_m.exists(code) || wd != is_word(code);
        host.xfer(wr, wd, code, d, rd, err, seen);
        check(16'(seen), 16'h1, "answer");
        check(16'(err), 16'(bad), "refusal");
        check(rd, (bad || wr) ? 16'h0000 : 16'(reg_m[code]), "rdata");
        if (!bad && wr)
            reg_m[code] = wd ? d : {8'h00, d[7:0]};
    endtask : access
    task clear_all();
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(3);
    endtask : clear_all
    task retry_run(input logic [2:0] cnt, input logic [2:0] t);
        int ex, win, rises, off_at;
        logic prev;
        ex = (int'(t) + 1) * fault_resp_pkg::RETRY_STEP_MS * MSC;
        win = (cnt == 3'h7 ? 5 : int'(cnt) + 1) * (ex + MSC + 4);
        rises = 0;
        off_at = 0;
        access(1'b1, 1'b0, 8'h56, {8'h00, fault_resp_pkg::MODE_RETRY, cnt, t});
        ov_fault_det = 1'b1;
        cyc(1);
        check(16'(output_en), 16'h0, "shutdown");
        for (int i = 1; i < win; i++)
        begin
            prev = output_en;
            cyc(1);
            if (prev && !output_en)
                off_at = i;
            if (!prev && output_en)
            begin
                rises++;
                check(16'(i - off_at >= ex + 1 && i - off_at <= ex + MSC), 16'h1, "gap");
            end
        end
        if (cnt == 3'h7)
            check(16'(rises >= 4), 16'h1, "endless");
        else
            check(16'(rises), 16'(cnt), "restarts");
        ov_fault_det = 1'b0;
        cyc(ex + MSC + 4);
        check(16'(output_en), 16'(cnt == 3'h7), "after fault");
        clear_all();
        check(16'(output_en), 16'h1, "cleared");
    endtask : retry_run
    task stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    initial
    begin
        #200000;
        mismatches++;
        stop_test();
    end
    initial
    begin
        reg_m[8'h52] = 16'h0000;
        reg_m[8'h54] = 16'h0080;
        reg_m[8'h55] = 16'hffff;
        reg_m[8'h56] = 16'h0080;
        reg_m[8'h57] = 16'hffff;
        cyc(3);
        check(16'({output_en, alert_line_n, ov_fault_flag, ut_fault_flag}), 16'h4, "reset");
        rstn = 1'b1;
        foreach (codes[k])
            access(1'b0, is_word(codes[k]), codes[k], 16'h0000);
        access(1'b0, 1'b1, 8'h53, 16'h0000);
        access(1'b1, 1'b0, 8'h55, 16'h1234);
        access(1'b1, 1'b1, 8'h56, 16'h1234);
        check(16'(output_en), 16'h1, "power up");
        $display("Test ended: reset and refusals");
        for (int ch = 0; ch < 2; ch++)
            for (int m = 0; m < 4; m++)
            begin
                access(1'b1, 1'b0, ch ? 8'h54 : 8'h56, 16'(m << 6));
                ov_fault_det = (ch == 0);
                ut_fault_det = (ch == 1);
                cyc(1);
                check(16'({alert_line_n, ov_fault_flag, ut_fault_flag}), ch ? 16'h1 : 16'h2, "flag");
                check(16'(output_en), 16'(m < 2), "mode");
                ov_fault_det = 1'b0;
                ut_fault_det = 1'b0;
                cyc(2);
                check(16'({alert_line_n, ov_fault_flag}), ch ? 16'h0 : 16'h1, "sticky");
                clear_all();
                check(16'({alert_line_n, output_en}), 16'h3, "recover");
            end
        $display("Test ended: response modes");
        for (int ch = 0; ch < 2; ch++)
        begin
            access(1'b1, 1'b0, ch ? 8'h54 : 8'h56, 16'h00c0);
            access(1'b1, 1'b1, ch ? 8'h52 : 8'h57, 16'h1000);
            vin_meas = 16'h1000;
            temp_meas = 16'h1000;
            ov_fault_det = (ch == 0);
            ut_fault_det = (ch == 1);
            cyc(1);
            ov_fault_det = 1'b0;
            ut_fault_det = 1'b0;
            cyc(6);
            check(16'(output_en), 16'h0, "at warning level");
            vin_meas = ch ? 16'h0000 : 16'h0fff;
            temp_meas = ch ? 16'h1001 : 16'h0000;
            cyc(2);
            check(16'(output_en), 16'h1, "resumed");
            clear_all();
        end
        $display("Test ended: resume");
        foreach (rcase[k])
            retry_run(rcase[k][5:3], rcase[k][2:0]);
        access(1'b1, 1'b0, 8'h56, 16'h00b8);
        ov_fault_det = 1'b1;
        cyc(3);
        ov_fault_det = 1'b0;
        output_cmd_on = 1'b0;
        cyc(1);
        check(16'(output_en), 16'h0, "commanded off");
        output_cmd_on = 1'b1;
        cyc(2);
        check(16'(output_en), 16'h1, "retry abandoned");
        clear_all();
        $display("Test ended: retries");
        for (int i = 0; i < 3; i++)
            foreach (codes[k])
            begin
                access(1'b1, is_word(codes[k]), codes[k], 16'($random(seed)));
                access(1'b0, is_word(codes[k]), codes[k], 16'h0000);
            end
        access(1'b1, 1'b1, 8'h53, 16'h5a5a);
        $display("Test ended: register traffic");
        stop_test();
    end
endmodule : input_fault_response_ctrl_test
